// ### design/pcit_timer.sv
// Periodic countdown interrupt timer with its serial register port
`include "pcit_regs.svh"
`default_nettype none
module pcit_timer #(
    parameter int REL_FAST_CYC = `PCIT_REL_FAST_NS / `PCIT_CLK_NS,
    parameter int REL_SLOW_CYC = `PCIT_REL_SLOW_NS / `PCIT_CLK_NS
) (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Serial register port, link clock domain
    input wire logic link_clk,
    input wire logic link_sel_n,
    input wire logic link_din,
    output logic link_dout,
    output logic link_dout_oe_n,
    // Ticks and state from the calendar circuit
    input wire logic tick_4096,
    input wire logic tick_64,
    input wire logic sec_update,
    input wire logic min_update,
    input wire logic cal_halt,
    // Shared open-drain interrupt pin
    input wire logic other_irq_req,
    output logic irq_n_out,
    output logic irq_n_oe_n,
    // Observed state
    output pcit_pkg::pcit_src_t tick_source,
    output logic period_event
);
    import pcit_pkg::*;

    // Link domain state
    pcit_link_st_t lk_st_r;
    logic [2:0] lk_bit_r;
    logic [7:0] lk_sh_r;
    logic [7:0] lk_tx_r;
    logic [3:0] lk_addr_r;
    logic [7:0] lk_wdata_r;
    logic lk_wr_pend_r;
    logic lk_rd_pend_r;
    logic [7:0] cmd_nxt;
    // System domain state
    logic wr_s1_r, wr_s2_r, wr_s3_r, rd_s1_r, rd_s2_r, rd_s3_r;
    logic [7:0] rd_word_r;
    logic [7:0] pre_lo_r, pre_hi_r, ext_r, ctrl_r;
    logic tf_r;
    logic [11:0] cnt_r;
    logic irq_low_r;
    logic [`PCIT_REL_W-1:0] rel_r;
    logic wr_evt, rd_evt, run_rise, tick_sel, halted, evt, timer_drive, flag_clr;
    logic [11:0] preset;

    // Selected source tick, calendar ticks keep the update alignment
    function automatic logic pick_tick(input logic [1:0] s, input logic a, input logic b,
                                       input logic c, input logic d);
        case (s)
            SRC_4096: pick_tick = a;
            SRC_64: pick_tick = b;
            SRC_SEC: pick_tick = c;
            default: pick_tick = d;
        endcase
    endfunction

    // Release time in cycles for the chosen source
    function automatic logic [`PCIT_REL_W-1:0] rel_cycles(input logic [1:0] s);
        if (s == SRC_4096)
            rel_cycles = `PCIT_REL_W'(REL_FAST_CYC);
        else
            rel_cycles = `PCIT_REL_W'(REL_SLOW_CYC);
    endfunction

    assign cmd_nxt = {lk_sh_r[6:0], link_din};

    // Link byte engine; frame end is the only reset since the clock stops between frames
    always_ff @(posedge link_clk or posedge link_sel_n)
    begin
        if (link_sel_n)
        begin
            lk_st_r <= LK_CMD;
            lk_bit_r <= 3'h0;
            lk_sh_r <= 8'h00;
            lk_tx_r <= 8'h00;
            lk_wr_pend_r <= 1'b0;
            lk_rd_pend_r <= 1'b0;
            link_dout <= 1'b0;
            link_dout_oe_n <= 1'b1;
        end
        else
        begin
            lk_bit_r <= lk_bit_r + 3'h1;
            case (lk_st_r)
                LK_CMD:
                begin
                    lk_sh_r <= cmd_nxt;
                    if (lk_bit_r == `PCIT_LAST_BIT)
                    begin
                        lk_rd_pend_r <= cmd_nxt[`PCIT_BIT_READ];
                        lk_st_r <= cmd_nxt[`PCIT_BIT_READ] ? LK_WAIT : LK_WR;
                    end
                end
                LK_WR:
                begin
                    lk_sh_r <= cmd_nxt;
                    if (lk_bit_r == `PCIT_LAST_BIT)
                    begin
                        lk_wr_pend_r <= 1'b1; // Last bit edge starts the write
                        lk_st_r <= LK_DONE;
                    end
                end
                LK_WAIT:
                begin
                    // Eight idle bits give the system side time to fetch the word
                    if (lk_bit_r == `PCIT_LAST_BIT)
                    begin
                        lk_tx_r <= {rd_word_r[6:0], 1'b0};
                        link_dout <= rd_word_r[7];
                        link_dout_oe_n <= 1'b0;
                        lk_st_r <= LK_RD;
                    end
                end
                LK_RD:
                begin
                    lk_tx_r <= {lk_tx_r[6:0], 1'b0};
                    link_dout <= lk_tx_r[7];
                    if (lk_bit_r == `PCIT_LAST_BIT)
                    begin
                        link_dout_oe_n <= 1'b1;
                        lk_st_r <= LK_DONE;
                    end
                end
                default: lk_st_r <= LK_DONE;
            endcase
        end
    end

    // Address and write data survive the frame end so the system side can still take them
    always_ff @(posedge link_clk)
    begin
        if (!link_sel_n && lk_st_r == LK_CMD && lk_bit_r == `PCIT_LAST_BIT)
            lk_addr_r <= cmd_nxt[3:0];
        if (!link_sel_n && lk_st_r == LK_WR && lk_bit_r == `PCIT_LAST_BIT)
            lk_wdata_r <= cmd_nxt;
    end

    // Request levels into the system domain, third stage only for edge detection
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            {wr_s1_r, wr_s2_r, wr_s3_r} <= 3'h0;
            {rd_s1_r, rd_s2_r, rd_s3_r} <= 3'h0;
        end
        else
        begin
            {wr_s1_r, wr_s2_r, wr_s3_r} <= {lk_wr_pend_r, wr_s1_r, wr_s2_r};
            {rd_s1_r, rd_s2_r, rd_s3_r} <= {lk_rd_pend_r, rd_s1_r, rd_s2_r};
        end
    end

    assign wr_evt = wr_s2_r & ~wr_s3_r;
    assign rd_evt = rd_s2_r & ~rd_s3_r;
    assign preset = {pre_hi_r[`PCIT_PRE_HI_MSB:0], pre_lo_r};
    assign run_rise = wr_evt && lk_addr_r == `PCIT_OFS_EXT && lk_wdata_r[`PCIT_BIT_RUN]
        && !ext_r[`PCIT_BIT_RUN];
    assign flag_clr = wr_evt && lk_addr_r == `PCIT_OFS_FLAG && !lk_wdata_r[`PCIT_BIT_TF];
    assign tick_source = pcit_src_t'(ext_r[`PCIT_TSEL_HI:`PCIT_TSEL_LO]);
    // Source select gates the countdown, calendar halt only for the 64, second and minute sources
    assign tick_sel = pick_tick(ext_r[`PCIT_TSEL_HI:`PCIT_TSEL_LO], tick_4096, tick_64,
        sec_update, min_update);
    assign halted = cal_halt && tick_source != SRC_4096;
    assign evt = ext_r[`PCIT_BIT_RUN] && tick_sel && !halted && cnt_r == `PCIT_ONE_CNT;
    assign period_event = evt;

    // Register writes; presets keep all bits, upper nibble is storage
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            pre_lo_r <= `PCIT_RST_BYTE;
            pre_hi_r <= `PCIT_RST_BYTE;
            ext_r <= `PCIT_RST_BYTE;
            ctrl_r <= `PCIT_RST_BYTE;
        end
        else if (wr_evt)
        begin
            case (lk_addr_r)
                `PCIT_OFS_PRE_LO: pre_lo_r <= lk_wdata_r;
                `PCIT_OFS_PRE_HI: pre_hi_r <= lk_wdata_r;
                `PCIT_OFS_EXT: ext_r <= lk_wdata_r;
                `PCIT_OFS_CTRL: ctrl_r <= lk_wdata_r & `PCIT_CTRL_WMASK;
                default: ;
            endcase
        end
    end

    // Event flag: set wins over a same-cycle clear, writing one does nothing
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            tf_r <= 1'b0;
        else if (evt)
            tf_r <= 1'b1;
        else if (flag_clr)
            tf_r <= 1'b0;
    end

    // Read word captured once the read request crosses over; the link takes it later
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rd_word_r <= 8'h00;
        else if (rd_evt)
        begin
            case (lk_addr_r)
                `PCIT_OFS_PRE_LO: rd_word_r <= pre_lo_r;
                `PCIT_OFS_PRE_HI: rd_word_r <= pre_hi_r;
                `PCIT_OFS_EXT: rd_word_r <= ext_r;
                `PCIT_OFS_FLAG: rd_word_r <= 8'(tf_r) << `PCIT_BIT_TF;
                `PCIT_OFS_CTRL: rd_word_r <= ctrl_r;
                default: rd_word_r <= 8'h00;
            endcase
        end
    end

    // Countdown with load on start and reload after each event
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            cnt_r <= `PCIT_ZERO_CNT;
        else if (run_rise)
            cnt_r <= preset;
        else if (evt)
            cnt_r <= preset;
        else if (ext_r[`PCIT_BIT_RUN] && tick_sel && !halted && cnt_r != `PCIT_ZERO_CNT)
            cnt_r <= cnt_r - `PCIT_ONE_CNT; // Zero count stays idle
    end

    // Auto-release timer for the low output; flag clears do not touch it
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            irq_low_r <= 1'b0;
            rel_r <= '0;
        end
        else if (evt && ctrl_r[`PCIT_BIT_TIE])
        begin
            irq_low_r <= 1'b1;
            rel_r <= rel_cycles(ext_r[`PCIT_TSEL_HI:`PCIT_TSEL_LO]);
        end
        else if (!ext_r[`PCIT_BIT_RUN] || !ctrl_r[`PCIT_BIT_TIE])
            irq_low_r <= 1'b0;
        else if (irq_low_r)
        begin
            rel_r <= rel_r - `PCIT_REL_W'(1);
            if (rel_r == `PCIT_REL_W'(1))
                irq_low_r <= 1'b0;
        end
    end

    // Gating by run and enable makes release immediate, not a cycle late
    assign timer_drive = irq_low_r && ext_r[`PCIT_BIT_RUN] && ctrl_r[`PCIT_BIT_TIE];
    assign irq_n_out = 1'b0;
    assign irq_n_oe_n = !(timer_drive || other_irq_req);

    // Checks on counting, flag and pin behaviour
    // Each selected tick above one takes exactly one step off the count
    property p_evt_one;
        @(posedge sys_clk) disable iff (srst)
            ext_r[`PCIT_BIT_RUN] && tick_sel && !halted && cnt_r > `PCIT_ONE_CNT && !run_rise
            |=> cnt_r == $past(cnt_r) - `PCIT_ONE_CNT;
    endproperty
    a_evt_one: assert property (p_evt_one) else $error("count did not step per tick");

    property p_load;
        @(posedge sys_clk) disable iff (srst) run_rise |=> cnt_r == $past(preset);
    endproperty
    a_load: assert property (p_load) else $error("start did not load preset");

    property p_reload;
        @(posedge sys_clk) disable iff (srst) evt && !run_rise |=> cnt_r == $past(preset);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload after event");

    property p_halt;
        @(posedge sys_clk) disable iff (srst) halted && !run_rise |=> $stable(cnt_r);
    endproperty
    a_halt: assert property (p_halt) else $error("counted while calendar halted");

    property p_tf_set;
        @(posedge sys_clk) disable iff (srst) evt |=> tf_r ##1 (tf_r || $past(flag_clr));
    endproperty
    a_tf_set: assert property (p_tf_set) else $error("event flag not held");

    property p_tf_w1;
        @(posedge sys_clk) disable iff (srst)
            !tf_r && !evt && wr_evt && lk_addr_r == `PCIT_OFS_FLAG |=> !tf_r;
    endproperty
    a_tf_w1: assert property (p_tf_w1) else $error("write set the event flag");

    property p_irq_on;
        @(posedge sys_clk) disable iff (srst)
            evt && ctrl_r[`PCIT_BIT_TIE] && !wr_evt |=> !irq_n_oe_n;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("enabled event not driven low");

    property p_irq_off;
        @(posedge sys_clk) disable iff (srst)
            (!ctrl_r[`PCIT_BIT_TIE] || !ext_r[`PCIT_BIT_RUN]) && !other_irq_req |-> irq_n_oe_n;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("timer drove pin while off");

    property p_rel;
        @(posedge sys_clk) disable iff (srst)
            evt && ctrl_r[`PCIT_BIT_TIE] |=> int'(rel_r) ==
            (($past(tick_source) == SRC_4096) ? REL_FAST_CYC : REL_SLOW_CYC);
    endproperty
    a_rel: assert property (p_rel) else $error("wrong auto-release time");

    // Flag clear in mid-pulse must leave the pin alone
    property p_keep_low;
        @(posedge sys_clk) disable iff (srst)
            timer_drive && flag_clr && rel_r > `PCIT_REL_W'(1) |=> timer_drive;
    endproperty
    a_keep_low: assert property (p_keep_low) else $error("flag clear released pin");

    property p_zero_bit;
        @(posedge sys_clk) disable iff (srst) (ctrl_r & ~`PCIT_CTRL_WMASK) == 8'h00;
    endproperty
    a_zero_bit: assert property (p_zero_bit) else $error("fixed zero bit set");

    // A stopped timer may not keep its pulse alive
    property p_stop_rel;
        @(posedge sys_clk) disable iff (srst) !ext_r[`PCIT_BIT_RUN] |=> !irq_low_r;
    endproperty
    a_stop_rel: assert property (p_stop_rel) else $error("stopped timer kept pin low");

    // Main scenarios the bench should reach

    c_event: cover property (@(posedge sys_clk) disable iff (srst) evt);
    c_release: cover property (@(posedge sys_clk) disable iff (srst) $fell(irq_low_r));
    c_write: cover property (@(posedge sys_clk) disable iff (srst) run_rise);
    c_read: cover property (@(posedge sys_clk) disable iff (srst) rd_evt);
    c_halt: cover property (@(posedge sys_clk) disable iff (srst) halted && tick_sel);
endmodule
`default_nettype wire

// ### pkg/pcit_pkg.sv
// Types shared by the countdown timer design
`default_nettype none
package pcit_pkg;
    typedef enum logic [2:0] {LK_CMD, LK_WR, LK_WAIT, LK_RD, LK_DONE} pcit_link_st_t;
    typedef enum logic [1:0] {SRC_4096, SRC_64, SRC_SEC, SRC_MIN} pcit_src_t;
endpackage
`default_nettype wire

// ### pkg/pcit_regs.svh
// Register offsets, bit positions, reset values and timing constants of the countdown timer
`ifndef PCIT_REGS_SVH
`define PCIT_REGS_SVH

// Register offsets on the serial port
`define PCIT_OFS_PRE_LO 4'hB
`define PCIT_OFS_PRE_HI 4'hC
`define PCIT_OFS_EXT 4'hD
`define PCIT_OFS_FLAG 4'hE
`define PCIT_OFS_CTRL 4'hF

// Field positions
`define PCIT_BIT_RUN 4
`define PCIT_BIT_TF 4
`define PCIT_BIT_TIE 4
`define PCIT_BIT_READ 7
`define PCIT_TSEL_HI 1
`define PCIT_TSEL_LO 0
`define PCIT_PRE_HI_MSB 3

// Reset value and writable-bit mask (bit 1 of control is fixed zero)
`define PCIT_RST_BYTE 8'h00
`define PCIT_CTRL_WMASK 8'hFD
`define PCIT_ZERO_CNT 12'h000
`define PCIT_ONE_CNT 12'h001

// Serial frame: last bit index of a byte
`define PCIT_LAST_BIT 3'h7

// Clock period and auto-release times in ns, and release counter width
`define PCIT_CLK_NS 20
`define PCIT_REL_FAST_NS 122000
`define PCIT_REL_SLOW_NS 7812500
`define PCIT_REL_W 19

`endif

// ### tb/pcit_host_model.sv
// Host model driving the serial register port of the countdown timer
`default_nettype none
module pcit_host_model (
    // Serial clock, select and data towards the timer
    output var logic link_clk,
    output var logic link_sel_n,
    output var logic link_din,
    // Read data back from the timer
    input wire logic link_dout,
    input wire logic link_dout_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 24;

    // Idle bus; one select edge clears the link logic before any frame
    initial
    begin
        link_clk = 1'b0;
        link_din = 1'b0;
        link_sel_n = 1'b0;
        #1;
        link_sel_n = 1'b1;
    end

    // One frame: command, data or wait bits, then read bits sampled on the next edge
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
        logic [15:0] sh;
        sh = {cmd, wdat};
        rdat = 8'h00;
        link_sel_n = 1'b0;
        for (int i = 0; i < 25; i++)
        begin
            // Past the two bytes the line keeps toggling so stale data never looks valid
            link_din = (i < 16) ? sh[15 - i] : ~link_din;
            #(HALF);
            // Bit launched on the previous edge; undriven line floats high
            if (i >= 16 && i < 24)
                rdat = {rdat[6:0], (link_dout_oe_n ? 1'b1 : link_dout)};
            link_clk = 1'b1;
            #(HALF);
            link_clk = 1'b0;
        end
        // Clock stands still between frames
        #(4 * HALF);
        link_sel_n = 1'b1;
        link_din = ~link_din;
        #(100);
    endtask
endmodule
`default_nettype wire

// ### tb/pcit_timer_tb_top.sv
// Self-checking bench for the periodic countdown timer
`include "pcit_regs.svh"
`default_nettype none
module pcit_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int REL_F = 6;
    localparam int REL_S = 300;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] tk = 4'h0;
    logic cal_halt = 1'b0;
    logic other_irq_req = 1'b0;
    logic irq_n_out;
    logic irq_n_oe_n;
    pcit_pkg::pcit_src_t tick_source;
    logic period_event;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int m_cnt = 0;
    int m_pre = 0;
    bit m_en = 0;
    bit m_flag = 0;
    logic [7:0] v;
    int ptab[4] = '{2, 1, 3, 1};

    logic link_clk;
    logic link_sel_n;
    logic link_din;
    logic link_dout;
    logic link_dout_oe_n;

    pcit_host_model pcit_host_model_inst (
        .link_clk(link_clk), .link_sel_n(link_sel_n), .link_din(link_din),
        .link_dout(link_dout), .link_dout_oe_n(link_dout_oe_n)
    );

    pcit_timer #(.REL_FAST_CYC(REL_F), .REL_SLOW_CYC(REL_S)) pcit_timer_inst (
        .sys_clk(sys_clk), .srst(srst),
        .link_clk(link_clk), .link_sel_n(link_sel_n), .link_din(link_din),
        .link_dout(link_dout), .link_dout_oe_n(link_dout_oe_n),
        .tick_4096(tk[0]), .tick_64(tk[1]), .sec_update(tk[2]), .min_update(tk[3]),
        .cal_halt(cal_halt), .other_irq_req(other_irq_req), .irq_n_out(irq_n_out),
        .irq_n_oe_n(irq_n_oe_n), .tick_source(tick_source), .period_event(period_event)
    );

    // System clock
    always #10 sys_clk = ~sys_clk;

    // Hang guard, well above the expected run length
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
        logic [7:0] r;
        pcit_host_model_inst.xfer({4'h0, ofs}, d, r);
    endtask

    task automatic rd(input logic [3:0] ofs, input logic [7:0] exp);
        logic [7:0] r;
        pcit_host_model_inst.xfer({4'h8, ofs}, 8'h00, r);
        check({8'h00, r}, {8'h00, exp});
    endtask

    // One tick of source s; the model decides event, then with win set the pin low time is counted
    task automatic tick(input int s, input bit win);
        bit ev;
        int low;
        @(negedge sys_clk);
        cal_halt = win && ($urandom_range(0, 3) == 0);
        tk = 4'($urandom) | (4'h1 << s);
        ev = 0;
        if (!(cal_halt && s != 0) && m_cnt != 0)
        begin
            ev = (m_cnt == 1);
            m_cnt = ev ? m_pre : m_cnt - 1;
        end
        m_flag |= ev;
        #2;
        check({15'h0, period_event}, {15'h0, ev});
        @(negedge sys_clk);
        tk = 4'h0;
        cal_halt = 1'b0;
        low = int'(irq_n_oe_n === 1'b0); // First low cycle already stands here
        if (win)
        begin
            repeat (REL_S + 20) @(negedge sys_clk) low += (irq_n_oe_n === 1'b0);
            check(16'(low), (ev && m_en) ? 16'(s == 0 ? REL_F : REL_S) : 16'h0);
        end
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(76));
        repeat (16) @(negedge sys_clk);
        srst = 1'b0;
        v = 8'($urandom);
        wr(`PCIT_OFS_PRE_LO, v);
        rd(`PCIT_OFS_PRE_LO, v);
        v = 8'($urandom);
        wr(`PCIT_OFS_PRE_HI, v);
        rd(`PCIT_OFS_PRE_HI, v);
        v = 8'($urandom);
        wr(`PCIT_OFS_CTRL, v);
        rd(`PCIT_OFS_CTRL, v & 8'hFD);
        wr(`PCIT_OFS_FLAG, 8'hFF);
        rd(`PCIT_OFS_FLAG, 8'h00);
        wr(4'hA, 8'h5A);
        rd(4'hA, 8'h00);
        @(negedge sys_clk);
        other_irq_req = 1'b1;
        #2;
        check({15'h0, irq_n_oe_n}, 16'h0);
        check({15'h0, irq_n_out}, 16'h0);
        other_irq_req = 1'b0;
        #2;
        check({15'h0, irq_n_oe_n}, 16'h1);
        // Every tick source, host stops the timer before touching settings
        for (int s = 0; s < 4; s++)
        begin
            wr(`PCIT_OFS_EXT, 8'(s));
            wr(`PCIT_OFS_CTRL, 8'h00);
            wr(`PCIT_OFS_PRE_LO, 8'(ptab[s]));
            wr(`PCIT_OFS_PRE_HI, 8'($urandom) & 8'hF0);
            wr(`PCIT_OFS_CTRL, 8'h10);
            wr(`PCIT_OFS_EXT, 8'h10 | 8'(s));
            check(16'(tick_source), 16'(s));
            m_pre = ptab[s];
            m_cnt = m_pre;
            m_en = 1;
            repeat (2 * ptab[s]) tick(s, 1);
            rd(`PCIT_OFS_FLAG, {3'b000, m_flag, 4'h0});
            wr(`PCIT_OFS_FLAG, 8'hFF);
            rd(`PCIT_OFS_FLAG, {3'b000, m_flag, 4'h0});
            wr(`PCIT_OFS_FLAG, 8'h00);
            rd(`PCIT_OFS_FLAG, 8'h00);
            m_flag = 0;
            wr(`PCIT_OFS_EXT, 8'(s));
        end
        // Pin held through flag clear, released by enable clear and by stop
        wr(`PCIT_OFS_PRE_LO, 8'h01);
        wr(`PCIT_OFS_PRE_HI, 8'h00);
        wr(`PCIT_OFS_EXT, 8'h11);
        m_pre = 1;
        m_cnt = 1;
        tick(1, 0);
        wr(`PCIT_OFS_FLAG, 8'h00);
        check({15'h0, irq_n_oe_n}, 16'h0);
        wr(`PCIT_OFS_CTRL, 8'h00);
        check({15'h0, irq_n_oe_n}, 16'h1);
        m_en = 0;
        tick(1, 1);
        wr(`PCIT_OFS_CTRL, 8'h10);
        m_en = 1;
        tick(1, 0);
        wr(`PCIT_OFS_EXT, 8'h01);
        check({15'h0, irq_n_oe_n}, 16'h1);
        m_cnt = 0;
        tick(1, 1);
        // Zero preset gives no events
        wr(`PCIT_OFS_PRE_LO, 8'h00);
        wr(`PCIT_OFS_EXT, 8'h10);
        m_pre = 0;
        repeat (3) tick(0, 1);
        wr(`PCIT_OFS_EXT, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
